// ---- thpr_pkg.sv ----
// Shared constants and types for the tunnel header parser and pipe router
package thpr_pkg;
  localparam int HDR_FIXED_BYTES = 12;
  localparam int HDR_TS_BYTES = 4;
  localparam int POS_ADDR = 0;
  localparam int POS_PORT = 4;
  localparam int POS_LEN = 6;
  localparam int POS_GROUP = 8;
  localparam int POS_KIND = 10;
  localparam int POS_FLAGS = 11;
  localparam int FLAG_RAP_BIT = 7;
  localparam int FLAG_TLIM_BIT = 6;
  localparam logic [7:0] KIND_SIG_LO = 8'h01;
  localparam logic [7:0] KIND_SIG_HI = 8'h05;
  localparam logic [7:0] KIND_SIG_TOP = 8'h0F;
  localparam logic [1:0] MEMB_NONE = 2'h0;
  localparam logic [1:0] MEMB_V2 = 2'h2;
  localparam logic [1:0] MEMB_V3 = 2'h3;
  localparam logic [15:0] PIPE_RESET = 16'h0000;
  typedef enum logic [1:0] {
    ST_HDR = 2'b00,
    ST_TS = 2'b01,
    ST_BODY = 2'b10
  } thpr_state_type;
endpackage

// ---- thpr_map_entry.sv ----
// One mapping table slot with address, port and pipe, plus a match flag
`timescale 1ns/1ps
module thpr_map_entry
  import thpr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic clr,
  input wire logic [31:0] wr_ip,
  input wire logic [15:0] wr_port,
  input wire logic [15:0] wr_pipe,
  input wire logic [31:0] q_ip,
  input wire logic [15:0] q_port,
  output logic hit,
  output logic [15:0] pipe
);
  logic valid_r;
  logic [31:0] ip_r;
  logic [15:0] port_r;
  logic [15:0] pipe_r;

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      valid_r <= 1'b0;
    end else if (wr) begin
      valid_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ip_r <= 32'h0;
      port_r <= 16'h0;
      pipe_r <= PIPE_RESET;
    end else if (wr) begin
      ip_r <= wr_ip;
      port_r <= wr_port;
      pipe_r <= wr_pipe;
    end
  end

  assign hit = valid_r && (ip_r == q_ip) && (port_r == q_port); // [R9]
  assign pipe = pipe_r;
endmodule // thpr_map_entry

// ---- thpr_hdr_shift.sv ----
// Byte-wide capture of the fixed header into a wide register
`timescale 1ns/1ps
module thpr_hdr_shift
  import thpr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [7:0] din,
  output logic [8*HDR_FIXED_BYTES-1:0] hdr
);
  logic [8*HDR_FIXED_BYTES-1:0] hdr_r;

  // Most significant byte first, so the first byte ends at the top
  always_ff @(posedge clk) begin
    if (rst) begin
      hdr_r <= '0;
    end else if (load) begin
      hdr_r <= {hdr_r[8*HDR_FIXED_BYTES-9:0], din};
    end
  end

  assign hdr = hdr_r;
endmodule // thpr_hdr_shift

// ---- thpr_router.sv ----
// Tunnel information header parser and pipe router
//
// Overview of operation
// [R1] Sender puts one information header before each inner packet start.
// [R2] First header field: 32-bit destination address, MSB first.
// [R3] Next field: 16-bit destination port of the following packet.
// [R4] Then 16-bit total inner packet length in bytes.
// [R5] Remaining length is tracked across tunnel payload boundaries.
// [R6] Group field is a group id for signaling kinds, else service id.
// [R7] Two wakeup bits meaningful for kinds 1..5, else zero.
// [R8] Four zero bits follow; 32-bit timestamp only if time-limit set.
// [R9] Header address and port are compared with each mapping entry.
// [R10] A matching packet goes to that entry's pipe.
// [R11] No match sends the packet to the tunnel's default pipe.
// [R12] An empty table sends every packet to the default pipe.
// [R13] Tunnel identified by destination address and port, any cast.
// [R14] Membership version 2 or 3, or none when unset.
// [R15] Version 3 needs a configured tunnel source address.
// [R16] Primary lost: join backup by its source address with version 3.
// [R17] Headers are stripped and never reach the output stream.
// [R18] Each inner stream has a unique address and port, one pipe.
// [R19] Routing uses header fields only; packet body stays opaque.
// [R20] Sender copies the inner destination address into the header.
// [R21] Service id comes from the service list definition.
// [R22] Payload kind is an 8-bit value describing the next packet.
// [R23] Wakeup bits are read only for signaling kinds 1 to 5.
// [R24] Mapping table is loaded before traffic, plus a default pipe.
// [R25] Random-access bit then time-limit bit follow the kind byte.
`timescale 1ns/1ps
module thpr_router
  import thpr_pkg::*;
#(
  parameter int ENTRIES = 8
)
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [31:0] CFG_DEST_IP,
  input wire logic [15:0] CFG_DEST_UDP_PORT,
  input wire logic [31:0] CFG_SOURCE_IP,
  input wire logic [31:0] CFG_BACKUP_SOURCE_IP,
  input wire logic CFG_BACKUP_VALID,
  input wire logic [1:0] CFG_MEMB_VERSION,
  input wire logic [15:0] CFG_DEFAULT_PIPE,
  input wire logic MAP_WR,
  input wire logic MAP_CLEAR,
  input wire logic [$clog2(ENTRIES)-1:0] MAP_IDX,
  input wire logic [31:0] MAP_DEST_IP,
  input wire logic [15:0] MAP_DEST_PORT,
  input wire logic [15:0] MAP_PIPE,
  input wire logic PRIMARY_UP,
  input wire logic TUN_VALID,
  input wire logic [31:0] TUN_DEST_IP,
  input wire logic [15:0] TUN_DEST_PORT,
  input wire logic [7:0] TUN_DATA,
  output logic OUT_VALID,
  output logic [7:0] OUT_DATA,
  output logic OUT_SOP,
  output logic OUT_EOP,
  output logic [15:0] OUT_PIPE,
  output logic [15:0] OUT_GROUP,
  output logic OUT_GROUP_IS_SIG,
  output logic [7:0] OUT_KIND,
  output logic OUT_RAP,
  output logic [1:0] OUT_WAKEUP,
  output logic [31:0] OUT_TIMESTAMP,
  output logic OUT_TS_VALID,
  output logic HDR_ERROR,
  output logic JOIN_EN,
  output logic [1:0] JOIN_VERSION,
  output logic [31:0] JOIN_SOURCE_IP,
  output logic JOIN_USE_SOURCE,
  output logic JOIN_BACKUP,
  output logic CFG_ERROR
);
  localparam int IW = $clog2(ENTRIES);
  localparam int CW = $clog2(HDR_FIXED_BYTES + 1);

  thpr_state_type state_r, state_nxt;
  logic [CW-1:0] cnt_r;
  logic [15:0] remain_r, out_len_r;
  logic [31:0] ts_r;
  logic [8*HDR_FIXED_BYTES-1:0] hdr;
  logic [ENTRIES-1:0] hit;
  logic [15:0] pipe_of [ENTRIES];
  logic [15:0] route_pipe;
  logic out_valid_r, out_sop_r, out_eop_r, ts_valid_r, hdr_err_r;
  logic [7:0] out_data_r;
  logic [15:0] out_pipe_r, out_group_r;
  logic out_sig_r, out_rap_r;
  logic [7:0] out_kind_r;
  logic [1:0] out_wake_r;
  logic [31:0] out_ts_r;
  logic join_en_r, join_src_r, join_bk_r, cfg_err_r;
  logic [1:0] join_ver_r;
  logic [31:0] join_ip_r;

  // Tunnel filter: only bytes of the configured tunnel are parsed
  wire tun_hit = TUN_VALID && (TUN_DEST_IP == CFG_DEST_IP)
    && (TUN_DEST_PORT == CFG_DEST_UDP_PORT); // [R13]
  wire in_hdr = tun_hit && (state_r == ST_HDR);
  wire in_ts = tun_hit && (state_r == ST_TS);
  wire in_body = tun_hit && (state_r == ST_BODY);
  wire hdr_last = in_hdr && (cnt_r == CW'(HDR_FIXED_BYTES - 1));
  wire ts_last = in_ts && (cnt_r == CW'(HDR_TS_BYTES - 1));
  wire body_last = in_body && (remain_r == 16'h1);

  // Header view including the byte arriving this cycle
  wire [8*HDR_FIXED_BYTES-1:0] hv = {hdr[8*HDR_FIXED_BYTES-9:0], TUN_DATA};
  wire [31:0] h_ip = hv[8*(HDR_FIXED_BYTES-POS_ADDR)-1 -: 32]; // [R2]
  wire [15:0] h_port = hv[8*(HDR_FIXED_BYTES-POS_PORT)-1 -: 16]; // [R3]
  wire [15:0] h_len = hv[8*(HDR_FIXED_BYTES-POS_LEN)-1 -: 16]; // [R4]
  wire [15:0] h_group = hv[8*(HDR_FIXED_BYTES-POS_GROUP)-1 -: 16];
  wire [7:0] h_kind = hv[8*(HDR_FIXED_BYTES-POS_KIND)-1 -: 8]; // [R22]
  wire [7:0] h_flags = hv[8*(HDR_FIXED_BYTES-POS_FLAGS)-1 -: 8];
  wire h_rap = h_flags[FLAG_RAP_BIT]; // [R25]
  wire h_tlim = h_flags[FLAG_TLIM_BIT]; // [R25]
  wire h_sig = (h_kind >= KIND_SIG_LO) && (h_kind <= KIND_SIG_TOP); // [R6]
  wire h_wk_kind = (h_kind >= KIND_SIG_LO) && (h_kind <= KIND_SIG_HI);
  // Reserved bits must be zero; wakeup bits reserved outside kinds 1..5
  wire h_bad = (h_flags[3:0] != 4'h0)
    || (!h_wk_kind && (h_flags[5:4] != 2'h0)) // [R7] [R8]
    || (h_len == 16'h0);

  thpr_hdr_shift u_shift (
    .clk(MCLK),
    .rst(RESET),
    .load(in_hdr),
    .din(TUN_DATA),
    .hdr(hdr)
  );

  for (genvar gi = 0; gi < ENTRIES; gi++) begin : g_map
    thpr_map_entry u_ent ( // [R24]
      .clk(MCLK),
      .rst(RESET),
      .wr(MAP_WR && (MAP_IDX == IW'(gi))),
      .clr(MAP_CLEAR),
      .wr_ip(MAP_DEST_IP),
      .wr_port(MAP_DEST_PORT),
      .wr_pipe(MAP_PIPE),
      .q_ip(h_ip),
      .q_port(h_port),
      .hit(hit[gi]),
      .pipe(pipe_of[gi])
    );
  end

  // Lowest matching index wins; unique addresses make ties unlikely
  always_comb begin
    route_pipe = CFG_DEFAULT_PIPE; // [R11] [R12]
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (hit[i]) begin
        route_pipe = pipe_of[i]; // [R10]
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_HDR: begin
        if (hdr_last && !h_bad) begin
          state_nxt = h_tlim ? ST_TS : ST_BODY; // [R8]
        end
      end
      ST_TS: begin
        if (ts_last) begin
          state_nxt = ST_BODY;
        end
      end
      ST_BODY: begin
        if (body_last) begin
          state_nxt = ST_HDR;
        end
      end
      default: state_nxt = ST_HDR;
    endcase
  end

  // Byte counter restarts at every header and timestamp end
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state_r <= ST_HDR;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (hdr_last || ts_last) ? '0 : cnt_r + CW'(in_hdr || in_ts);
    end
  end

  // Remaining count persists while no tunnel bytes arrive
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      remain_r <= 16'h0;
      out_len_r <= 16'h0;
    end else if (hdr_last) begin
      remain_r <= h_len; // [R5]
      out_len_r <= h_len;
    end else if (in_body) begin
      remain_r <= remain_r - 16'h1; // [R5]
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ts_r <= 32'h0;
    end else if (in_ts) begin
      ts_r <= {ts_r[23:0], TUN_DATA};
    end
  end

  // Per-packet routing attributes, latched at header end
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      out_pipe_r <= PIPE_RESET;
      out_group_r <= 16'h0;
      out_sig_r <= 1'b0;
      out_kind_r <= 8'h0;
      out_rap_r <= 1'b0;
      out_wake_r <= 2'h0;
    end else if (hdr_last && !h_bad) begin
      out_pipe_r <= route_pipe; // [R9] [R19]
      out_group_r <= h_group; // [R6]
      out_sig_r <= h_sig;
      out_kind_r <= h_kind;
      out_rap_r <= h_rap;
      out_wake_r <= h_wk_kind ? h_flags[5:4] : 2'h0; // [R7] [R23]
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      out_ts_r <= 32'h0;
      ts_valid_r <= 1'b0;
    end else if (hdr_last && !h_bad) begin
      ts_valid_r <= 1'b0;
    end else if (ts_last) begin
      out_ts_r <= {ts_r[23:0], TUN_DATA};
      ts_valid_r <= 1'b1;
    end
  end

  // Only body bytes are forwarded; header bytes never leave
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      out_valid_r <= 1'b0;
      out_data_r <= 8'h0;
      out_sop_r <= 1'b0;
      out_eop_r <= 1'b0;
      hdr_err_r <= 1'b0;
    end else begin
      out_valid_r <= in_body; // [R17]
      out_data_r <= in_body ? TUN_DATA : 8'h0; // [R19]
      out_sop_r <= in_body && (remain_r == out_len_r);
      out_eop_r <= body_last;
      hdr_err_r <= hdr_last && h_bad; // [R7] [R8]
    end
  end

  // Membership join control; backup only meaningful with source filtering
  wire use_bk = !PRIMARY_UP && CFG_BACKUP_VALID; // [R16]
  wire memb_on = (CFG_MEMB_VERSION == MEMB_V2)
    || (CFG_MEMB_VERSION == MEMB_V3); // [R14]
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      join_en_r <= 1'b0;
      join_ver_r <= MEMB_NONE;
      join_ip_r <= 32'h0;
      join_src_r <= 1'b0;
      join_bk_r <= 1'b0;
      cfg_err_r <= 1'b0;
    end else begin
      join_en_r <= memb_on || use_bk; // [R14]
      join_ver_r <= use_bk ? MEMB_V3 : (memb_on ? CFG_MEMB_VERSION
        : MEMB_NONE); // [R16]
      join_ip_r <= use_bk ? CFG_BACKUP_SOURCE_IP : CFG_SOURCE_IP; // [R15]
      join_src_r <= use_bk || (CFG_MEMB_VERSION == MEMB_V3); // [R15]
      join_bk_r <= use_bk;
      cfg_err_r <= (CFG_MEMB_VERSION == MEMB_V3)
        && (CFG_SOURCE_IP == 32'h0); // [R15]
    end
  end

  assign OUT_VALID = out_valid_r;
  assign OUT_DATA = out_data_r;
  assign OUT_SOP = out_sop_r;
  assign OUT_EOP = out_eop_r;
  assign OUT_PIPE = out_pipe_r;
  assign OUT_GROUP = out_group_r;
  assign OUT_GROUP_IS_SIG = out_sig_r;
  assign OUT_KIND = out_kind_r;
  assign OUT_RAP = out_rap_r;
  assign OUT_WAKEUP = out_wake_r;
  assign OUT_TIMESTAMP = out_ts_r;
  assign OUT_TS_VALID = ts_valid_r;
  assign HDR_ERROR = hdr_err_r;
  assign JOIN_EN = join_en_r;
  assign JOIN_VERSION = join_ver_r;
  assign JOIN_SOURCE_IP = join_ip_r;
  assign JOIN_USE_SOURCE = join_src_r;
  assign JOIN_BACKUP = join_bk_r;
  assign CFG_ERROR = cfg_err_r;

  sequence s_hdr_end;
    hdr_last && !h_bad;
  endsequence

  a_header_strip: assert property (@(posedge MCLK) disable iff (RESET)
    in_hdr |=> !out_valid_r) // [R17]
    else $error("header byte forwarded");
  a_pipe_default: assert property (@(posedge MCLK) disable iff (RESET)
    s_hdr_end ##0 (hit == '0) |=> out_pipe_r == $past(CFG_DEFAULT_PIPE))
    else $error("unmatched packet not on default pipe"); // [R11]
  a_pipe_match: assert property (@(posedge MCLK) disable iff (RESET)
    s_hdr_end ##0 hit[0] |=> out_pipe_r == $past(pipe_of[0]))
    else $error("matched packet on wrong pipe"); // [R10]
  a_len_load: assert property (@(posedge MCLK) disable iff (RESET)
    s_hdr_end |=> remain_r == $past(h_len))
    else $error("length not loaded"); // [R5]
  a_ts_follow: assert property (@(posedge MCLK) disable iff (RESET)
    s_hdr_end ##0 h_tlim |=> state_r == ST_TS)
    else $error("timestamp not expected"); // [R8]
  a_no_ts: assert property (@(posedge MCLK) disable iff (RESET)
    s_hdr_end ##0 !h_tlim |=> state_r == ST_BODY)
    else $error("timestamp wrongly expected"); // [R8]
  a_wake_zero: assert property (@(posedge MCLK) disable iff (RESET)
    s_hdr_end ##0 !h_wk_kind |=> out_wake_r == 2'h0)
    else $error("wakeup bits outside kinds 1..5"); // [R7]
  a_backup_v3: assert property (@(posedge MCLK) disable iff (RESET)
    use_bk |=> join_ver_r == MEMB_V3 && join_bk_r)
    else $error("backup join not version 3"); // [R16]
  a_body_out: assert property (@(posedge MCLK) disable iff (RESET)
    in_body |=> out_valid_r && out_data_r == $past(TUN_DATA))
    else $error("body byte lost"); // [R19]
endmodule // thpr_router

// ---- thpr_src_model.sv ----
// Behavioural data source that feeds tunnel bytes to the router
`timescale 1ns/1ps
module thpr_src_model #(
  parameter logic [31:0] TUN_IP = 32'hEF010203,
  parameter logic [15:0] TUN_PORT = 16'h1F90
)
(
  input wire logic clk,
  input wire logic slow,
  output logic tun_valid,
  output logic [7:0] tun_data,
  output logic [31:0] tun_dest_ip,
  output logic [15:0] tun_dest_port
);
  logic [8:0] q[$];
  logic gap = 1'b0;

  initial begin
    tun_valid = 1'b0;
    tun_data = 8'h00;
    tun_dest_ip = 32'h00000000;
    tun_dest_port = 16'h0000;
  end

  task automatic send_pkt(input logic [31:0] ip, input logic [15:0] port,
      input logic [15:0] len, input logic [15:0] grp, input logic [7:0] kind,
      input logic [7:0] flags, input logic [31:0] ts, input logic [7:0] base,
      input logic body, input logic foreign);
    logic [95:0] h;
    h = {ip, port, len, grp, kind, flags};
    for (int i = 11; i >= 0; i--) q.push_back({foreign, h[8*i +: 8]});
    if (flags[6]) begin
      for (int i = 3; i >= 0; i--) q.push_back({foreign, ts[8*i +: 8]});
    end
    if (body) begin
      for (int i = 0; i < len; i++) q.push_back({foreign, base + i[7:0]});
    end
  endtask

  always @(negedge clk) begin
    gap <= slow ? ~gap : 1'b0;
    if (q.size() > 0 && !(slow && gap)) begin
      tun_valid <= 1'b1;
      tun_data <= q[0][7:0];
      tun_dest_ip <= q[0][8] ? ~TUN_IP : TUN_IP;
      tun_dest_port <= TUN_PORT;
      void'(q.pop_front());
    end else begin
      // Idle line shows the last byte inverted, flipping back on each further idle cycle
      tun_valid <= 1'b0;
      tun_data <= ~tun_data;
    end
  end
endmodule // thpr_src_model

// ---- thpr_router_tb.sv ----
// Self-checking testbench for the tunnel header parser and pipe router
`timescale 1ns/1ps
module thpr_router_tb;
  import thpr_pkg::*;
  localparam logic [31:0] TIP = 32'hEF010203;
  localparam logic [15:0] TPORT = 16'h1F90;
  localparam logic [31:0] IP_A = 32'hE0000101;
  localparam logic [31:0] IP_B = 32'hE0000202;
  localparam logic [15:0] P1 = 16'h1388;
  localparam logic [15:0] P2 = 16'h1389;
  localparam logic [15:0] DEF = 16'h00D0;
  logic MCLK = 1'b0, RESET = 1'b1, slow = 1'b0;
  logic [31:0] CFG_SOURCE_IP = 32'h0, CFG_BACKUP_SOURCE_IP = 32'h0A000009;
  logic CFG_BACKUP_VALID = 1'b0, PRIMARY_UP = 1'b1;
  logic [1:0] CFG_MEMB_VERSION = 2'h0;
  logic MAP_WR = 1'b0, MAP_CLEAR = 1'b0;
  logic [2:0] MAP_IDX = 3'h0;
  logic [31:0] MAP_DEST_IP = 32'h0;
  logic [15:0] MAP_DEST_PORT = 16'h0, MAP_PIPE = 16'h0;
  logic TUN_VALID, OUT_VALID, OUT_SOP, OUT_EOP, OUT_GROUP_IS_SIG, OUT_RAP;
  logic [7:0] TUN_DATA, OUT_DATA, OUT_KIND;
  logic [31:0] TUN_DEST_IP, OUT_TIMESTAMP, JOIN_SOURCE_IP;
  logic [15:0] TUN_DEST_PORT, OUT_PIPE, OUT_GROUP;
  logic [1:0] OUT_WAKEUP, JOIN_VERSION;
  logic OUT_TS_VALID, HDR_ERROR, JOIN_EN, JOIN_USE_SOURCE, JOIN_BACKUP;
  logic CFG_ERROR;
  logic [25:0] expq[$];
  logic [60:0] attq[$];
  logic [60:0] a;
  logic [7:0] kinds [4] = '{8'h00, 8'h01, 8'h05, 8'h06};
  int errors = 0, cmp_count = 0, hdr_errs = 0, cycles = 0;

  thpr_router #(.ENTRIES(8)) thpr_router_inst (.MCLK(MCLK), .RESET(RESET),
    .CFG_DEST_IP(TIP), .CFG_DEST_UDP_PORT(TPORT),
    .CFG_SOURCE_IP(CFG_SOURCE_IP), .CFG_BACKUP_SOURCE_IP(CFG_BACKUP_SOURCE_IP),
    .CFG_BACKUP_VALID(CFG_BACKUP_VALID), .CFG_MEMB_VERSION(CFG_MEMB_VERSION),
    .CFG_DEFAULT_PIPE(DEF), .MAP_WR(MAP_WR), .MAP_CLEAR(MAP_CLEAR),
    .MAP_IDX(MAP_IDX), .MAP_DEST_IP(MAP_DEST_IP),
    .MAP_DEST_PORT(MAP_DEST_PORT), .MAP_PIPE(MAP_PIPE),
    .PRIMARY_UP(PRIMARY_UP), .TUN_VALID(TUN_VALID),
    .TUN_DEST_IP(TUN_DEST_IP), .TUN_DEST_PORT(TUN_DEST_PORT),
    .TUN_DATA(TUN_DATA), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA),
    .OUT_SOP(OUT_SOP), .OUT_EOP(OUT_EOP), .OUT_PIPE(OUT_PIPE),
    .OUT_GROUP(OUT_GROUP), .OUT_GROUP_IS_SIG(OUT_GROUP_IS_SIG),
    .OUT_KIND(OUT_KIND), .OUT_RAP(OUT_RAP), .OUT_WAKEUP(OUT_WAKEUP),
    .OUT_TIMESTAMP(OUT_TIMESTAMP), .OUT_TS_VALID(OUT_TS_VALID),
    .HDR_ERROR(HDR_ERROR), .JOIN_EN(JOIN_EN), .JOIN_VERSION(JOIN_VERSION),
    .JOIN_SOURCE_IP(JOIN_SOURCE_IP), .JOIN_USE_SOURCE(JOIN_USE_SOURCE),
    .JOIN_BACKUP(JOIN_BACKUP), .CFG_ERROR(CFG_ERROR));

  thpr_src_model #(.TUN_IP(TIP), .TUN_PORT(TPORT)) thpr_src_model_inst (
    .clk(MCLK), .slow(slow), .tun_valid(TUN_VALID), .tun_data(TUN_DATA),
    .tun_dest_ip(TUN_DEST_IP), .tun_dest_port(TUN_DEST_PORT));

  always #2.5 MCLK = ~MCLK;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Group derives from address and port, body bytes from port alone, to tell packets apart
  task automatic pkt(input logic [31:0] ip, input logic [15:0] port,
      input int len, input logic [7:0] kind, input logic [7:0] flags,
      input logic [15:0] pipe);
    logic sig;
    sig = kind >= KIND_SIG_LO && kind <= KIND_SIG_TOP;
    thpr_src_model_inst.send_pkt(ip, port, len[15:0], port ^ ip[15:0], kind,
      flags, {ip[7:0], 24'hC0FFEE}, port[7:0], 1'b1, 1'b0);
    for (int i = 0; i < len; i++)
      expq.push_back({i == 0, i == len - 1, pipe, port[7:0] + i[7:0]});
    attq.push_back({port ^ ip[15:0], sig, kind, flags[7], flags[5:4],
      flags[6], ip[7:0], 24'hC0FFEE});
  endtask

  task automatic map(input logic [2:0] idx, input logic [31:0] ip,
      input logic [15:0] port, input logic [15:0] pipe);
    MAP_IDX = idx;
    MAP_DEST_IP = ip;
    MAP_DEST_PORT = port;
    MAP_PIPE = pipe;
    MAP_WR = 1'b1;
    @(negedge MCLK);
    MAP_WR = 1'b0;
    // One idle cycle so back-to-back writes never re-raise the strobe
    @(negedge MCLK);
  endtask

  task automatic drain;
    for (int i = 0; i < 3000 && (thpr_src_model_inst.q.size() > 0 ||
        expq.size() > 0); i++) @(negedge MCLK);
    repeat (4) @(negedge MCLK);
    check(expq.size(), 0);
  endtask

  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run;
    end
  end

  // Registered outputs read mid-cycle, clear of the edge that launched them
  always @(negedge MCLK) begin
    if (HDR_ERROR === 1'b1) hdr_errs++;
    if (OUT_VALID === 1'b1) begin
      if (expq.size() == 0) check(1, 0);
      else check({OUT_SOP, OUT_EOP, OUT_PIPE, OUT_DATA},
        expq.pop_front());
      if (OUT_SOP === 1'b1 && attq.size() > 0) begin
        a = attq.pop_front();
        check({OUT_GROUP, OUT_GROUP_IS_SIG, OUT_KIND, OUT_RAP, OUT_WAKEUP,
          OUT_TS_VALID}, a[60:32]);
        if (a[32]) check(OUT_TIMESTAMP, a[31:0]);
      end
    end
  end

  initial begin
    repeat (3) @(negedge MCLK);
    RESET = 1'b0;
    // Distinct address and port per inner stream, one pipe each
    map(3'h0, IP_A, P1, 16'h0011);
    map(3'h7, IP_B, P2, 16'h0077);
    pkt(IP_A, P1, 3, 8'h01, 8'hA0, 16'h0011);
    pkt(IP_B, P2, 5, 8'h80, 8'h40, 16'h0077);
    pkt(IP_A, P2, 2, 8'hFF, 8'h00, DEF);
    drain;
    // Gaps split packets the way tunnel payload edges would
    slow = 1'b1;
    thpr_src_model_inst.send_pkt(IP_A, P1, 4, 16'h0, 8'h01, 8'h00, 32'h0,
      8'h00, 1'b1, 1'b1);
    pkt(IP_B, P2, 7, 8'h10, 8'hC0, 16'h0077);
    drain;
    slow = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (kinds[k] >= KIND_SIG_LO && kinds[k] <= KIND_SIG_HI)
        pkt(IP_A, P1, 2, kinds[k], 8'h10, 16'h0011);
      else
        thpr_src_model_inst.send_pkt(IP_A, P1, 2, 16'h0, kinds[k], 8'h10,
          32'h0, 8'h00, 1'b0, 1'b0);
    end
    thpr_src_model_inst.send_pkt(IP_A, P1, 2, 16'h0, 8'h01, 8'h01, 32'h0,
      8'h00, 1'b0, 1'b0);
    pkt(IP_B, P1, 1, 8'h05, 8'h30, DEF);
    drain;
    check(hdr_errs, 3);
    MAP_CLEAR = 1'b1;
    @(negedge MCLK);
    MAP_CLEAR = 1'b0;
    pkt(IP_A, P1, 2, 8'h02, 8'h00, DEF);
    drain;
    CFG_MEMB_VERSION = MEMB_V2;
    repeat (2) @(negedge MCLK);
    check({JOIN_EN, JOIN_VERSION, JOIN_USE_SOURCE, JOIN_BACKUP, CFG_ERROR},
      6'b110000);
    CFG_MEMB_VERSION = MEMB_V3;
    repeat (2) @(negedge MCLK);
    check(CFG_ERROR, 1);
    CFG_SOURCE_IP = 32'h0A000001;
    repeat (2) @(negedge MCLK);
    check({JOIN_EN, JOIN_VERSION, JOIN_USE_SOURCE, CFG_ERROR, JOIN_SOURCE_IP},
      {5'b11110, 32'h0A000001});
    CFG_MEMB_VERSION = MEMB_NONE;
    repeat (2) @(negedge MCLK);
    check({JOIN_EN, JOIN_BACKUP, CFG_ERROR}, 3'b000);
    CFG_MEMB_VERSION = MEMB_V2;
    PRIMARY_UP = 1'b0;
    CFG_BACKUP_VALID = 1'b1;
    repeat (2) @(negedge MCLK);
    check({JOIN_EN, JOIN_USE_SOURCE, JOIN_BACKUP, JOIN_VERSION,
      JOIN_SOURCE_IP}, {5'b11111, 32'h0A000009});
    complete_run;
  end
endmodule // thpr_router_tb
